// [src/ctmr_pkg.sv]
`default_nettype none
package ctmr_pkg;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int        CNT_BITS   = 10;
  localparam int        PER_SHIFT  = 7;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [10:0] MAX_PER  = 11'h400;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL0   = 8'h00;
  localparam logic [7:0] OFF_CTRL1   = 8'h04;
  localparam logic [7:0] OFF_CNT_LO  = 8'h08;
  localparam logic [7:0] OFF_CNT_HI  = 8'h0c;
  localparam logic [7:0] OFF_CMPA_LO = 8'h10;
  localparam logic [7:0] OFF_CMPA_HI = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;
  localparam logic [7:0] OFF_NONE    = 8'hff;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int C0_PAUSE = 7;
  localparam int C0_CKS   = 4;
  localparam int C0_ON    = 3;
  localparam int C0_RP    = 0;
  localparam int C1_MODE  = 6;
  localparam int C1_IO    = 4;
  localparam int C1_OC    = 3;
  localparam int C1_POL   = 2;
  localparam int C1_DPX   = 1;
  localparam int C1_CCLR  = 0;
  localparam int ST_PF    = 0;
  localparam int ST_AF    = 1;
  localparam int HTRANS_ACT = 1;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [2:0] CKS_DIV4  = 3'h0;
  localparam logic [2:0] CKS_DIV1  = 3'h1;
  localparam logic [2:0] CKS_DIV16 = 3'h2;
  localparam logic [2:0] CKS_DIV64 = 3'h3;
  localparam logic [2:0] CKS_LIRC0 = 3'h4;
  localparam logic [2:0] CKS_LIRC1 = 3'h5;
  localparam logic [2:0] CKS_RISE  = 3'h6;
  localparam logic [2:0] CKS_FALL  = 3'h7;
  localparam logic [5:0] MSK_DIV4  = 6'h03;
  localparam logic [5:0] MSK_DIV16 = 6'h0f;
  localparam logic [5:0] MSK_DIV64 = 6'h3f;
  localparam logic [1:0] MODE_CMP  = 2'h0;
  localparam logic [1:0] MODE_PWM  = 2'h2;
  localparam logic [1:0] MODE_TMR  = 2'h3;
  localparam logic [1:0] IO_NONE   = 2'h0;
  localparam logic [1:0] IO_LOW    = 2'h1;
  localparam logic [1:0] IO_HIGH   = 2'h2;
  localparam logic [1:0] IO_TOG    = 2'h3;
  localparam logic [1:0] IO_INACT  = 2'h0;
  localparam logic [1:0] IO_ACT    = 2'h1;
  localparam logic [1:0] IO_PWM    = 2'h2;

  // ****************************************
  // Module state
  // ****************************************
  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [9:0]  cnt;
    logic [9:0]  compare_register_a;
    logic [7:0]  lo_buf;
    logic [5:0]  presc;
    logic        on_prev;
    logic [2:0]  lirc_s;
    logic [2:0]  ext_s;
    logic        lvl;
    logic        pin;
    logic        oe;
    logic        flag_a;
    logic        flag_p;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        rd_pend;
    logic [7:0]  rd_addr;
    logic [31:0] hrdata;
    logic        hready;
  } ctmr_state_t;

endpackage
`default_nettype wire

// [src/ctmr_top.sv]
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Pause bit high holds the count; clearing it resumes from there.
// - Clock select picks sys/4, sys, /16, /64, slow osc, pin rise or fall.
// - Counter-on high runs the counter; low stops it and keeps the count.
// - Counter-on rising edge clears the counter; falling edge leaves it.
// - In compare mode, counter-on rising edge sets pin to initial level.
// - Period value matches counter bits 9..7, steps of 128, zero means 1024.
// - Period value zero lets the counter run to maximum and overflow.
// - Outside PWM mode, clear select 0 clears on period match, 1 on compare A match.
// - Mode field: 00 compare output, 01 undefined, 10 PWM, 11 timer.
// - Compare mode A match: none, drive low, drive high or toggle.
// - PWM output function: force inactive, force active, waveform.
// - Requested level equal to initial level shows no pin change.
// - Initial-level bit is pre-match level, or PWM active level.
// - Invert bit inverts the pin except in timer and undefined modes.
// - Swap bit 0: period value sets period, A duty; 1 swaps them.
// - Counter bits 9..8 read at high byte bits 1..0, rest zero.
// - Compare A held as low byte plus two bits of high byte, reset zero.
// - Low bytes go through a buffer moved on high byte access.
// - A match raises its own flag; period match raises its flag except with clear select 1 outside PWM mode.
// - Compare mode pin changes only on A match events and counter-on rising edge.
module ctmr_top
  import ctmr_pkg::*;
#(
  parameter int CNT_W = 10
)
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Timer pins
  input  wire logic        lirc_clk_in,
  input  wire logic        external_clock_pin_in,
  output logic             timer_output_pin_out,
  output logic             timer_output_pin_oe_out,
  output logic             compare_a_flag_out,
  output logic             period_match_flag_out
);

  if (CNT_W != CNT_BITS)
  begin : g_chk
    $error("ctmr_top: counter width must be 10");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] map_addr(input logic [31:0] a);
    logic [7:0] r;
    r = OFF_NONE;
    if (a[31:8] == 24'h000000)
    begin
      case (a[7:0])
        OFF_CTRL0, OFF_CTRL1, OFF_CNT_LO, OFF_CNT_HI,
        OFF_CMPA_LO, OFF_CMPA_HI, OFF_STATUS: r = a[7:0];
        default: r = OFF_NONE;
      endcase
    end
    return r;
  endfunction

  function automatic logic [31:0] rd_word(input ctmr_state_t st, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h00000000;
    case (a)
      OFF_CTRL0:   r[7:0] = st.ctrl0;
      OFF_CTRL1:   r[7:0] = st.ctrl1;
      OFF_CNT_LO:  r[7:0] = st.lo_buf;
      OFF_CNT_HI:  r[1:0] = st.cnt[9:8];
      OFF_CMPA_LO: r[7:0] = st.lo_buf;
      OFF_CMPA_HI: r[1:0] = st.compare_register_a[9:8];
      OFF_STATUS:  r[1:0] = {st.flag_a, st.flag_p};
      default:     r = 32'h00000000;
    endcase
    return r;
  endfunction

  ctmr_state_t s_reg;
  ctmr_state_t s_next;

  logic        tick;
  logic        run;
  logic        on_rise;
  logic        pm;
  logic        am;
  logic        clr;
  logic        pwm_act;
  logic [9:0]  inc;
  logic [10:0] duty;
  logic [2:0]  cks;
  logic [2:0]  rp;
  logic [1:0]  mode;
  logic [1:0]  io;
  logic        oc;
  logic        acc;

  assign cks  = s_reg.ctrl0[C0_CKS +: 3];
  assign rp   = s_reg.ctrl0[C0_RP +: 3];
  assign mode = s_reg.ctrl1[C1_MODE +: 2];
  assign io   = s_reg.ctrl1[C1_IO +: 2];
  assign oc   = s_reg.ctrl1[C1_OC];
  assign acc  = hsel_in & htrans_in[HTRANS_ACT] & hready_in;

  // ****************************************
  // Timer clock select
  // ****************************************
  // clock source decode
  always_comb
  begin
    unique case (cks)
      CKS_DIV4:           tick = (s_reg.presc & MSK_DIV4) == MSK_DIV4;
      CKS_DIV1:           tick = 1'b1;
      CKS_DIV16:          tick = (s_reg.presc & MSK_DIV16) == MSK_DIV16;
      CKS_DIV64:          tick = s_reg.presc == MSK_DIV64;
      CKS_LIRC0, CKS_LIRC1: tick = s_reg.lirc_s[1] & ~s_reg.lirc_s[2];
      CKS_RISE:           tick = s_reg.ext_s[1] & ~s_reg.ext_s[2];
      CKS_FALL:           tick = ~s_reg.ext_s[1] & s_reg.ext_s[2];
    endcase
  end

  // ****************************************
  // Comparators
  // ****************************************
  // pause and off both freeze counting
  assign run     = s_reg.ctrl0[C0_ON] & ~s_reg.ctrl0[C0_PAUSE] & tick;
  assign on_rise = s_reg.ctrl0[C0_ON] & ~s_reg.on_prev;
  assign inc     = s_reg.cnt + 10'h001;
  // period match on top three bits, zero means overflow
  assign pm = (rp == 3'h0) ? (inc == 10'h000)
                           : (inc[9:PER_SHIFT] == rp && inc[PER_SHIFT-1:0] == 7'h00);
  assign am = (s_reg.compare_register_a != 10'h000) && (inc == s_reg.compare_register_a);
  assign clr = (mode == MODE_PWM) ? (s_reg.ctrl1[C1_DPX] ? am : pm)
                                  : (s_reg.ctrl1[C1_CCLR] ? am : pm);
  assign duty = ~s_reg.ctrl1[C1_DPX] ? {1'b0, s_reg.compare_register_a}
              : (rp == 3'h0) ? MAX_PER : {1'b0, rp, 7'h00};
  assign pwm_act = {1'b0, s_reg.cnt} < duty;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_next         = s_reg;
    s_next.presc   = s_reg.presc + 6'h01;
    s_next.lirc_s  = {s_reg.lirc_s[1:0], lirc_clk_in};
    s_next.ext_s   = {s_reg.ext_s[1:0], external_clock_pin_in};
    s_next.on_prev = s_reg.ctrl0[C0_ON];
    s_next.hready  = 1'b1;

    // Bus write data phase
    if (s_reg.wr_pend)
    begin
      unique case (s_reg.wr_addr)
        OFF_CTRL0:   s_next.ctrl0 = hwdata_in[7:0];
        OFF_CTRL1:   s_next.ctrl1 = hwdata_in[7:0];
        // low byte only reaches the buffer
        OFF_CMPA_LO: s_next.lo_buf = hwdata_in[7:0];
        // high byte write latches buffered low byte
        OFF_CMPA_HI: s_next.compare_register_a = {hwdata_in[1:0], s_reg.lo_buf};
        OFF_STATUS:
        begin
          s_next.flag_p = s_reg.flag_p & ~hwdata_in[ST_PF];
          s_next.flag_a = s_reg.flag_a & ~hwdata_in[ST_AF];
        end
        default: s_next.wr_pend = 1'b0;
      endcase
    end
    s_next.wr_pend = acc & hwrite_in;
    s_next.wr_addr = map_addr(haddr_in);
    s_next.rd_pend = 1'b0;

    // Bus read, held one cycle behind a pending write
    if ((acc & ~hwrite_in & ~s_reg.wr_pend) | s_reg.rd_pend)
    begin
      s_next.hrdata = rd_word(s_reg, s_reg.rd_pend ? s_reg.rd_addr : map_addr(haddr_in));
      // high byte read captures low byte
      unique case (s_reg.rd_pend ? s_reg.rd_addr : map_addr(haddr_in))
        OFF_CNT_HI:  s_next.lo_buf = s_reg.cnt[7:0];
        OFF_CMPA_HI: s_next.lo_buf = s_reg.compare_register_a[7:0];
        default:     s_next.lo_buf = s_next.lo_buf;
      endcase
    end
    else if (acc & ~hwrite_in)
    begin
      s_next.rd_pend = 1'b1;
      s_next.rd_addr = map_addr(haddr_in);
      s_next.hready  = 1'b0;
    end

    // Counter
    if (on_rise)
    begin
      s_next.cnt = 10'h000;
      if (mode == MODE_CMP)
      begin
        s_next.lvl = oc;
      end
    end
    else if (run)
    begin
      s_next.cnt = clr ? 10'h000 : inc;
      // flags set after clears, so a set wins
      if (am)
      begin
        s_next.flag_a = 1'b1;
      end
      if (pm && (mode == MODE_PWM || !s_reg.ctrl1[C1_CCLR]))
      begin
        s_next.flag_p = 1'b1;
      end
      // compare mode acts on A match only
      if (am && mode == MODE_CMP)
      begin
        unique case (io)
          IO_NONE: s_next.lvl = s_reg.lvl;
          IO_LOW:  s_next.lvl = 1'b0;
          IO_HIGH: s_next.lvl = 1'b1;
          IO_TOG:  s_next.lvl = ~s_reg.lvl;
        endcase
      end
    end

    unique case (mode)
      MODE_CMP: s_next.pin = s_reg.lvl ^ s_reg.ctrl1[C1_POL];
      MODE_PWM:
      begin
        unique case (io)
          IO_ACT:  s_next.pin = oc ^ s_reg.ctrl1[C1_POL];
          IO_PWM:  s_next.pin = (pwm_act ? oc : ~oc) ^ s_reg.ctrl1[C1_POL];
          default: s_next.pin = ~oc ^ s_reg.ctrl1[C1_POL];
        endcase
      end
      default:  s_next.pin = 1'b0;
    endcase
    s_next.oe = s_reg.ctrl0[C0_ON] & (mode == MODE_CMP || mode == MODE_PWM);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      s_reg        <= '0;
      s_reg.ctrl0  <= RST_BYTE;
      s_reg.ctrl1  <= RST_BYTE;
      s_reg.hready <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign hrdata_out              = s_reg.hrdata;
  assign hreadyout_out           = s_reg.hready;
  assign hresp_out               = 1'b0;
  assign timer_output_pin_out    = s_reg.pin;
  assign timer_output_pin_oe_out = s_reg.oe;
  assign compare_a_flag_out      = s_reg.flag_a;
  assign period_match_flag_out   = s_reg.flag_p;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  sequence held_on;
    s_reg.ctrl0[C0_ON] && !on_rise;
  endsequence

  a_pause_hold: assert property (
    held_on and s_reg.ctrl0[C0_PAUSE] |=> $stable(s_reg.cnt))
    else $error("count moved while paused");
  a_off_retain: assert property (
    !s_reg.ctrl0[C0_ON] |=> s_reg.cnt == $past(s_reg.cnt))
    else $error("count moved while off");
  a_on_rise_clear: assert property (
    on_rise |=> s_reg.cnt == 10'h000)
    else $error("count not cleared on enable");
  a_rise_pin_init: assert property (
    on_rise && mode == MODE_CMP && $stable(s_reg.ctrl1) ##1 $stable(s_reg.ctrl1)
    |=> s_reg.pin == (oc ^ s_reg.ctrl1[C1_POL]))
    else $error("pin not at initial level");
  a_period_clear: assert property (
    held_on and run && rp != 3'h0 && mode == MODE_TMR && !s_reg.ctrl1[C1_CCLR]
    && s_reg.cnt == {rp - 3'h1, 7'h7f} |=> s_reg.cnt == 10'h000 && s_reg.flag_p)
    else $error("period match did not clear");
  a_overflow_wrap: assert property (
    run && !on_rise && rp == 3'h0 && s_reg.cnt == 10'h3ff |=> s_reg.cnt == 10'h000)
    else $error("no overflow wrap");
  a_div16_tick: assert property (
    cks == CKS_DIV16 && tick |=> !tick [*8])
    else $error("divide by sixteen too fast");
  a_cmp_toggle: assert property (
    run && !on_rise && am && mode == MODE_CMP && io == IO_TOG |=> s_reg.lvl != $past(s_reg.lvl))
    else $error("toggle did not toggle");
  a_compare_register_a_write: assert property (
    s_reg.wr_pend && s_reg.wr_addr == OFF_CMPA_HI
    |=> s_reg.compare_register_a == {$past(hwdata_in[1:0]), $past(s_reg.lo_buf)})
    else $error("compare A not latched");
  a_timer_no_oe: assert property (
    mode == MODE_TMR ##1 mode == MODE_TMR |-> !timer_output_pin_oe_out && !timer_output_pin_out)
    else $error("pin driven in timer mode");

  sequence pwm_forced;
    mode == MODE_PWM && io == IO_ACT;
  endsequence

  a_pwm_force: assert property (
    pwm_forced ##1 (pwm_forced and $stable(s_reg.ctrl1))
    |-> timer_output_pin_out == (oc ^ s_reg.ctrl1[C1_POL]))
    else $error("forced active level wrong");
  a_a_flag_set: assert property (
    run && !on_rise && am |=> s_reg.flag_a)
    else $error("compare A flag not raised");
  a_no_pflag: assert property (
    !s_reg.flag_p && mode != MODE_PWM && s_reg.ctrl1[C1_CCLR] |=> !s_reg.flag_p)
    else $error("period flag raised with A clear");
  a_pmatch_no_pin: assert property (
    run && !on_rise && pm && !am && mode == MODE_CMP |=> s_reg.lvl == $past(s_reg.lvl))
    else $error("period match moved the pin");

endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ctmr_pkg::*;
;
  logic        ref_clk_in;
  logic        srst_in;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        lirc = 1'b0;
  logic        ext = 1'b0;
  logic        pin;
  logic        oe;
  logic        fa;
  logic        fp;
  logic [31:0] rdat;
  int          n_mismatch;
  int          n_tests;
  int          tick = 0;
  int          divs[8]  = '{4, 1, 16, 64, 10, 10, 16, 16};
  logic [7:0]  offs[6]  = '{OFF_CTRL0, OFF_CTRL1, OFF_CNT_HI, OFF_CMPA_LO, OFF_CMPA_HI, OFF_STATUS};
  logic [7:0]  pc1[7]   = '{8'ha8, 8'hac, 8'ha0, 8'h98, 8'h88, 8'haa, 8'haa};
  logic [9:0]  pca[7]   = '{10'h020, 10'h020, 10'h020, 10'h020, 10'h020, 10'h100, 10'h040};
  int          pon[7]   = '{64, 192, 192, 256, 0, 128, 256};

  ctmr_top #(.CNT_W(10)) u_ctmr_top (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .lirc_clk_in(lirc), .external_clock_pin_in(ext), .timer_output_pin_out(pin),
    .timer_output_pin_oe_out(oe), .compare_a_flag_out(fa), .period_match_flag_out(fp));

  // ****************************************
  // Clock, slow sources, bus tasks
  // ****************************************
  initial
  begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // Slow oscillator one rise per 10 cycles, pin one edge pair per 16
  always @(posedge ref_clk_in)
  begin
    tick <= tick + 1;
    if (tick % 5 == 4) lirc <= ~lirc;
    if (tick % 8 == 7) ext <= ~ext;
  end

  task automatic wt();
    @(posedge ref_clk_in);
    while (hready !== 1'b1)
    begin
      @(posedge ref_clk_in);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wt();
    rdat = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask

  // high byte first, then buffered low byte
  task automatic rdcnt(output logic [31:0] c);
    logic [1:0] h;
    rd(OFF_CNT_HI);
    h = rdat[1:0];
    rd(OFF_CNT_LO);
    c = {22'h0, h, rdat[7:0]};
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic near(int a, int b, int t);
    return (a >= b - t) && (a <= b + t);
  endfunction

  function automatic logic cmp_exp(logic [1:0] io, logic oc);
    case (io)
      IO_NONE: return oc;
      IO_LOW:  return 1'b0;
      IO_HIGH: return 1'b1;
      default: return ~oc;
    endcase
  endfunction

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge ref_clk_in);
    n_mismatch++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [31:0] c1;
    logic [31:0] c2;
    int n;
    logic [9:0] v;
    logic [1:0] io;
    logic oc;
    logic pol;
    hsel = 1'b1; hwrite = 1'b0; htrans = 2'h0; haddr = 32'h0; hwdata = 32'h0;
    srst_in = 1'b1; n_mismatch = 0; n_tests = 0;
    void'($urandom(4));
    repeat (4) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    @(posedge ref_clk_in);
    for (int i = 0; i < 6; i++)
    begin
      rd(offs[i]);
      chk("reset value", rdat, 32'h0);
    end
    wr(8'h1c, 8'h5a);
    rd(8'h1c);
    chk("unmapped", rdat, 32'h0);
    chk("bus response", {31'h0, hresp}, 32'h0);
    wr(OFF_CNT_HI, 8'h03);
    rd(OFF_CNT_HI);
    chk("counter high read only", rdat, 32'h0);
    v = 10'($urandom);
    wr(OFF_CMPA_LO, v[7:0]);
    wr(OFF_CMPA_HI, {6'h0, v[9:8]});
    wr(OFF_CMPA_LO, ~v[7:0]);
    rd(OFF_CMPA_HI);
    chk("cmpa high", rdat, {30'h0, v[9:8]});
    rd(OFF_CMPA_LO);
    chk("cmpa low", rdat, {24'h0, v[7:0]});
    wr(OFF_CTRL1, 8'hc0);
    for (int k = 0; k < 8; k++)
    begin
      wr(OFF_CTRL0, {1'b0, 3'(k), 4'h8});
      repeat (640) @(posedge ref_clk_in);
      wr(OFF_CTRL0, {1'b1, 3'(k), 4'h8});
      rdcnt(c1);
      chk("count per source", near(c1, 640 / divs[k], 6), 1'b1);
      repeat (50) @(posedge ref_clk_in);
      rdcnt(c2);
      chk("paused count", c2, c1);
      chk("timer mode enable", oe, 1'b0);
      wr(OFF_CTRL0, {1'b0, 3'(k), 4'h0});
      rdcnt(c2);
      chk("off count", c2, c1);
    end
    wr(OFF_CMPA_LO, 8'h32);
    wr(OFF_CMPA_HI, 8'h00);
    wr(OFF_STATUS, 8'h03);
    wr(OFF_CTRL0, 8'h19);
    repeat (300) @(posedge ref_clk_in);
    chk("period flag", fp, 1'b1);
    chk("a flag", fa, 1'b1);
    rdcnt(c1);
    chk("period clear", c1 < 128, 1'b1);
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_STATUS, 8'h03);
    rd(OFF_STATUS);
    chk("status cleared", rdat, 32'h0);
    wr(OFF_CTRL1, 8'hc1);
    wr(OFF_CTRL0, 8'h19);
    repeat (300) @(posedge ref_clk_in);
    chk("no period flag", fp, 1'b0);
    chk("a flag clear mode", fa, 1'b1);
    rdcnt(c1);
    chk("a clear", c1 < 50, 1'b1);
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_CMPA_LO, 8'hc8);
    wr(OFF_CMPA_HI, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      io = k[1:0];
      oc = k[2];
      pol = 1'($urandom);
      wr(OFF_CTRL1, {2'b00, io, oc, pol, 2'b01});
      wr(OFF_CTRL0, 8'h19);
      repeat (100) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk("pin initial", pin, oc ^ pol);
      chk("pin enable", oe, 1'b1);
      repeat (140) @(negedge ref_clk_in);
      chk("pin after match", pin, cmp_exp(io, oc) ^ pol);
      wr(OFF_CTRL0, 8'h00);
    end
    for (int i = 0; i < 7; i++)
    begin
      wr(OFF_CTRL1, pc1[i]);
      wr(OFF_CMPA_LO, pca[i][7:0]);
      wr(OFF_CMPA_HI, {6'h0, pca[i][9:8]});
      wr(OFF_CTRL0, 8'h19);
      repeat (20) @(posedge ref_clk_in);
      n = 0;
      repeat (256)
      begin
        @(negedge ref_clk_in);
        n += int'(pin);
      end
      chk("pwm active cycles", n, pon[i]);
      wr(OFF_CTRL0, 8'h00);
    end
    wr(OFF_CTRL1, 8'h40);
    wr(OFF_CTRL0, 8'h19);
    repeat (4) @(negedge ref_clk_in);
    chk("undefined mode enable", oe, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
